// ==== hbcdf_pkg.sv ====
package hbcdf_pkg;

	// Clock and timing figures.
	localparam int CLK_FREQ_HZ   = 100_000_000;
	localparam int PWM_FREQ_HZ   = 50_000;
	localparam int BLANK_TIME_NS = 3750;
	localparam int MIXED_PCT     = 75;

	localparam int PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_HZ;
	localparam int BLANK_CYC      = (BLANK_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int MIXED_CYC      = (PWM_PERIOD_CYC * MIXED_PCT) / 100;

	localparam int               PWM_CNT_W  = 11;
	localparam int               BLANK_CNT_W = 9;
	localparam logic [10:0]      PWM_LAST   = 11'(PWM_PERIOD_CYC - 1);
	localparam logic [10:0]      PWM_MIXED  = 11'(MIXED_CYC);
	localparam logic [8:0]       BLANK_DONE = 9'(BLANK_CYC);

	// Register map, byte addresses on APB.
	localparam logic [7:0]  ADDR_CFG    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [15:0] OCP_QUAL_RST = 16'h0064;

	// Status field positions.
	localparam int ST_OCP_LSB   = 0;
	localparam int ST_THERMAL   = 2;
	localparam int ST_SUPPLY_UNDERVOLTAGE_TRIP      = 3;
	localparam int ST_SLEEP     = 4;
	localparam int ST_CLEAR     = 5;
	localparam int ST_FAULT_PIN = 6;
	localparam int ST_DECAY_LSB = 8;
	localparam int ST_CHOP0_LSB = 12;
	localparam int ST_CHOP1_LSB = 20;

	typedef enum logic [2:0] {
		DECAY_SLOW  = 3'h1,
		DECAY_MIXED = 3'h2,
		DECAY_FAST  = 3'h4
	} hbcdf_decay_e;

	typedef enum logic [4:0] {
		CHOP_IDLE  = 5'h01,
		CHOP_DRIVE = 5'h02,
		CHOP_FAST  = 5'h04,
		CHOP_COAST = 5'h08,
		CHOP_SLOW  = 5'h10
	} hbcdf_chop_e;

	// One half-bridge: high-side and low-side gate enables.
	typedef struct packed {
		logic hs;
		logic ls;
	} hbcdf_half_s;

	typedef struct packed {
		hbcdf_half_s a;
		hbcdf_half_s b;
	} hbcdf_bridge_s;

	localparam hbcdf_half_s HALF_OFF  = 2'h0;
	localparam hbcdf_half_s HALF_HIGH = 2'h2;
	localparam hbcdf_half_s HALF_LOW  = 2'h1;

endpackage : hbcdf_pkg

// ==== hbcdf_core.sv ====
`timescale 1ns/100ps

// Summary of operation
// RULE1: Drive until chop comparator trips, then decay.
// RULE2: Fast decay reverses bridge, off near zero.
// RULE3: Slow decay turns on both low sides.
// RULE4: Decay pin: low slow, open mixed, high fast.
// RULE5: One decay selection serves both bridges.
// RULE6: Mixed decay: fast, then slow at 75%.
// RULE7: Ignore sense comparator during 3.75 us blanking.
// RULE8: Blanking sets the minimum drive-on time.
// RULE9: Clear pin low resets logic, bridges off.
// RULE10: Power-down pin low stops pump, regulator, clocks.
// RULE11: Host waits about 1 ms after wake.
// RULE12: Host drives clear and power-down pins high.
// RULE13: Qualified overcurrent disables bridge, asserts fault.
// RULE14: High-side, low-side and winding shorts all trip.
// RULE15: Overcurrent stays latched until clear or supply loss.
// RULE16: Overcurrent detection independent of chop sense path.
// RULE17: Thermal trip disables switches, auto-resumes, asserts fault.
// RULE18: Undervoltage disables everything and resets logic.
// RULE19: Overcurrent qualification time is a configurable count.
// RULE20: Chopping periods start on fixed 50 kHz cadence.
// RULE21: After trip, drive stays off until next period.
// RULE22: Bridge inputs map 00 Z, 01 LH, 10 HL, 11 LL.
// RULE23: Scale pins: 00 full, 01 71%, 10 38%, 11 off.
module hbcdf_core (
	input  wire logic                         clk_sys,
	input  wire logic                         reset_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [1:0]                   bridge_ctrl_in_a,
	input  wire logic [1:0]                   bridge_ctrl_in_b,
	input  wire logic [1:0]                   current_scale_msb,
	input  wire logic [1:0]                   current_scale_lsb,
	input  wire logic                         decay_sel_level,
	input  wire logic                         decay_sel_driven,
	input  wire logic [1:0]                   chop_trip,
	input  wire logic [1:0]                   winding_near_zero,
	input  wire logic [1:0]                   overcurrent_trip,
	input  wire logic                         thermal_trip,
	input  wire logic                         supply_undervoltage_trip,
	input  wire logic                         active_low_logic_clear,
	input  wire logic                         active_low_power_down,
	output hbcdf_pkg::hbcdf_half_s [1:0]      bridge_out_a,
	output hbcdf_pkg::hbcdf_half_s [1:0]      bridge_out_b,
	output logic      [3:0]                   chop_scale_sel,
	output logic                              charge_pump_en,
	output logic                              aux_regulator_en,
	input  wire logic                         fault_flag_out_i,
	output logic                              fault_flag_out_o,
	output logic                              fault_flag_out_oe
);
	import hbcdf_pkg::*;

	logic                 awake;
	logic                 logic_ok;
	logic [PWM_CNT_W-1:0] pwm_cnt_reg;
	logic                 period_end;
	hbcdf_decay_e         decay_mode_reg;
	logic [15:0]          ocp_qual_reg;
	logic [1:0]           ocp_latched_reg;
	logic                 fault_any;
	hbcdf_chop_e          chop_state_reg [2];
	logic [1:0]           run;
	logic [31:0]          status_word;
	logic [31:0]          prdata_reg;
	logic                 cfg_hit;
	logic                 status_hit;

	// Sleep and undervoltage both hold the core idle; in sleep the
	// counters are frozen at zero, which stands in for the stopped clocks.
	assign awake    = active_low_power_down;
	assign logic_ok = active_low_logic_clear && active_low_power_down
	                  && !supply_undervoltage_trip; // see RULE9 see RULE18

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			charge_pump_en   <= 1'b0;
			aux_regulator_en <= 1'b0;
		end else begin
			charge_pump_en   <= awake && !supply_undervoltage_trip; // see RULE10
			aux_regulator_en <= awake && !supply_undervoltage_trip; // see RULE10
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pwm_cnt_reg <= '0;
		end else if (!logic_ok || period_end) begin
			pwm_cnt_reg <= '0; // see RULE20
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + 11'h001;
		end
	end
	assign period_end = (pwm_cnt_reg == PWM_LAST);

	// The open pin is seen as undriven; mixed is also the safe default.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			decay_mode_reg <= DECAY_MIXED;
		end else if (!logic_ok) begin
			decay_mode_reg <= DECAY_MIXED;
		end else if (!decay_sel_driven) begin
			decay_mode_reg <= DECAY_MIXED; // see RULE4
		end else if (decay_sel_level) begin
			decay_mode_reg <= DECAY_FAST; // see RULE4
		end else begin
			decay_mode_reg <= DECAY_SLOW; // see RULE4
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			chop_scale_sel <= 4'hF;
		end else if (!logic_ok) begin
			chop_scale_sel <= 4'hF;
		end else begin
			chop_scale_sel <= {current_scale_msb[1], current_scale_lsb[1],
			                   current_scale_msb[0], current_scale_lsb[0]}; // see RULE23
		end
	end

	assign fault_any = (|ocp_latched_reg) || (thermal_trip && logic_ok);

	// Open-drain fault line: only ever pulled low.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fault_flag_out_oe <= 1'b0;
		end else begin
			fault_flag_out_oe <= fault_any; // see RULE13 see RULE17
		end
	end
	assign fault_flag_out_o = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bridge
			logic [15:0]            ocp_cnt_reg;
			logic [BLANK_CNT_W-1:0] blank_cnt_reg;
			logic                   blank_over;
			logic                   scale_off;
			hbcdf_bridge_s          fwd;
			hbcdf_bridge_s          rev;
			hbcdf_bridge_s          drive;

			assign scale_off  = current_scale_msb[gi] && current_scale_lsb[gi]; // see RULE23
			assign run[gi]    = logic_ok && !thermal_trip && !ocp_latched_reg[gi]
			                    && !scale_off; // see RULE17
			assign blank_over = (blank_cnt_reg >= BLANK_DONE);

			// Overcurrent uses its own per-bridge limit flag, never chop_trip,
			// so it trips whatever the sense resistor or reference.
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					ocp_cnt_reg         <= '0;
					ocp_latched_reg[gi] <= 1'b0;
				end else if (!active_low_logic_clear || supply_undervoltage_trip) begin
					ocp_cnt_reg         <= '0;
					ocp_latched_reg[gi] <= 1'b0; // see RULE15
				end else if (!awake) begin
					ocp_cnt_reg         <= '0;
				end else if (overcurrent_trip[gi]) begin // see RULE14 see RULE16
					if (ocp_cnt_reg >= ocp_qual_reg) begin
						ocp_latched_reg[gi] <= 1'b1; // see RULE13 see RULE19
					end else begin
						ocp_cnt_reg <= ocp_cnt_reg + 16'h0001;
					end
				end else begin
					ocp_cnt_reg <= '0;
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					blank_cnt_reg <= '0;
				end else if (chop_state_reg[gi] != CHOP_DRIVE) begin
					blank_cnt_reg <= '0;
				end else if (!blank_over) begin
					blank_cnt_reg <= blank_cnt_reg + 9'h001; // see RULE7
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					chop_state_reg[gi] <= CHOP_IDLE;
				end else if (!run[gi]) begin
					chop_state_reg[gi] <= CHOP_IDLE;
				end else if (period_end) begin
					chop_state_reg[gi] <= CHOP_DRIVE; // see RULE20 see RULE21
				end else begin
					case (chop_state_reg[gi])
						CHOP_DRIVE: begin
							// Trips inside the blanking window are ignored,
							// which also fixes the least on time.
							if (blank_over && chop_trip[gi]) begin // see RULE1 see RULE7 see RULE8
								if (decay_mode_reg == DECAY_SLOW) begin
									chop_state_reg[gi] <= CHOP_SLOW; // see RULE3 see RULE5
								end else if (decay_mode_reg == DECAY_MIXED
								             && pwm_cnt_reg >= PWM_MIXED) begin
									chop_state_reg[gi] <= CHOP_SLOW; // see RULE6
								end else begin
									chop_state_reg[gi] <= CHOP_FAST; // see RULE2 see RULE6
								end
							end
						end
						CHOP_FAST, CHOP_COAST: begin
							if (decay_mode_reg == DECAY_MIXED && pwm_cnt_reg >= PWM_MIXED) begin
								chop_state_reg[gi] <= CHOP_SLOW; // see RULE6
							end else if (winding_near_zero[gi]) begin
								chop_state_reg[gi] <= CHOP_COAST; // see RULE2
							end
						end
						CHOP_SLOW: begin
							chop_state_reg[gi] <= CHOP_SLOW; // see RULE3
						end
						CHOP_IDLE: begin
							chop_state_reg[gi] <= CHOP_IDLE;
						end
						default: begin
							chop_state_reg[gi] <= CHOP_IDLE;
						end
					endcase
				end
			end

			always_comb begin
				case ({bridge_ctrl_in_a[gi], bridge_ctrl_in_b[gi]})
					2'b01:   fwd = '{a: HALF_LOW, b: HALF_HIGH}; // see RULE22
					2'b10:   fwd = '{a: HALF_HIGH, b: HALF_LOW}; // see RULE22
					2'b11:   fwd = '{a: HALF_LOW, b: HALF_LOW}; // see RULE22
					default: fwd = '{a: HALF_OFF, b: HALF_OFF}; // see RULE22
				endcase
				rev = fwd;
				if (^{bridge_ctrl_in_a[gi], bridge_ctrl_in_b[gi]}) begin
					rev = '{a: fwd.b, b: fwd.a}; // see RULE2
				end
				case (chop_state_reg[gi])
					CHOP_DRIVE: drive = fwd;
					CHOP_FAST:  drive = rev;
					CHOP_SLOW:  drive = '{a: HALF_LOW, b: HALF_LOW}; // see RULE3
					default:    drive = '{a: HALF_OFF, b: HALF_OFF};
				endcase
			end

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					bridge_out_a[gi] <= HALF_OFF;
					bridge_out_b[gi] <= HALF_OFF;
				end else if (!run[gi]) begin
					bridge_out_a[gi] <= HALF_OFF; // see RULE9 see RULE13 see RULE17
					bridge_out_b[gi] <= HALF_OFF;
				end else begin
					bridge_out_a[gi] <= drive.a;
					bridge_out_b[gi] <= drive.b;
				end
			end
		end
	endgenerate

	// APB slave: zero wait states, read data captured in the setup cycle.
	assign cfg_hit    = (paddr == ADDR_CFG);
	assign status_hit = (paddr == ADDR_STATUS);
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !(cfg_hit || status_hit);
	assign prdata     = prdata_reg;

	always_comb begin
		status_word                                 = '0;
		status_word[ST_OCP_LSB +: 2]                = ocp_latched_reg;
		status_word[ST_THERMAL]                     = thermal_trip;
		status_word[ST_SUPPLY_UNDERVOLTAGE_TRIP]                        = supply_undervoltage_trip;
		status_word[ST_SLEEP]                       = !active_low_power_down;
		status_word[ST_CLEAR]                       = !active_low_logic_clear;
		status_word[ST_FAULT_PIN]                   = fault_flag_out_i;
		status_word[ST_DECAY_LSB +: 3]              = decay_mode_reg;
		status_word[ST_CHOP0_LSB +: 5]              = chop_state_reg[0];
		status_word[ST_CHOP1_LSB +: 5]              = chop_state_reg[1];
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdata_reg <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= cfg_hit ? {16'h0000, ocp_qual_reg}
			                      : (status_hit ? status_word : 32'h00000000);
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ocp_qual_reg <= OCP_QUAL_RST;
		end else if (psel && penable && pwrite && cfg_hit) begin
			ocp_qual_reg <= pwdata[15:0]; // see RULE19
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence s_tripped0;
		chop_state_reg[0] inside {CHOP_FAST, CHOP_COAST, CHOP_SLOW};
	endsequence

	sequence s_fresh_drive0;
		chop_state_reg[0] == CHOP_DRIVE && !g_bridge[0].blank_over && run[0];
	endsequence

	// A clear or sleep right after the wrap holds the counter at zero on purpose.
	AST_PERIOD_WRAP: assert property ( // see RULE20
		logic_ok && period_end |=> pwm_cnt_reg == 11'h000
		##1 (pwm_cnt_reg == 11'h001 || !$past(logic_ok)))
		else $error("PWM period did not restart on cadence");

	AST_CLEAR_OFF: assert property ( // see RULE9
		!active_low_logic_clear |=> bridge_out_a == '0 && bridge_out_b == '0)
		else $error("Bridges driven while logic clear is low");

	AST_SLEEP_OFF: assert property ( // see RULE10
		!active_low_power_down |=> !charge_pump_en && !aux_regulator_en && pwm_cnt_reg == 11'h000)
		else $error("Pump, regulator or clocks alive in sleep");

	AST_OCP_HOLD: assert property ( // see RULE15
		ocp_latched_reg[0] && active_low_logic_clear && !supply_undervoltage_trip
		|=> ocp_latched_reg[0] && fault_flag_out_oe)
		else $error("Overcurrent latch released without clear");

	AST_OCP_QUAL: assert property ( // see RULE13
		!ocp_latched_reg[0] && g_bridge[0].ocp_cnt_reg == 16'h0000 && ocp_qual_reg == 16'h0003
		&& active_low_logic_clear && active_low_power_down && !supply_undervoltage_trip
		&& overcurrent_trip[0] ##1 overcurrent_trip[0] [*3]
		|=> ocp_latched_reg[0] ##1 bridge_out_a[0] == HALF_OFF && bridge_out_b[0] == HALF_OFF)
		else $error("Qualified overcurrent did not shut bridge");

	AST_THERMAL: assert property ( // see RULE17
		thermal_trip && logic_ok |=> fault_flag_out_oe && bridge_out_a == '0 && bridge_out_b == '0)
		else $error("Thermal trip did not disable bridges");

	AST_BLANKING: assert property ( // see RULE7
		s_fresh_drive0 and (!period_end) |=> chop_state_reg[0] inside {CHOP_DRIVE, CHOP_IDLE})
		else $error("Chop trip acted inside blanking window");

	AST_HOLD_OFF: assert property ( // see RULE21
		s_tripped0 ##0 (run[0] && !period_end) |=> chop_state_reg[0] != CHOP_DRIVE)
		else $error("Drive resumed before next PWM period");

	AST_SLOW_LS: assert property ( // see RULE3
		chop_state_reg[0] == CHOP_SLOW && run[0]
		|=> bridge_out_a[0] == HALF_LOW && bridge_out_b[0] == HALF_LOW)
		else $error("Slow decay did not enable both low sides");

	AST_MIXED: assert property ( // see RULE6
		decay_mode_reg == DECAY_MIXED && chop_state_reg[0] == CHOP_FAST && run[0]
		&& !period_end && pwm_cnt_reg >= PWM_MIXED |=> chop_state_reg[0] == CHOP_SLOW)
		else $error("Mixed decay missed switch to slow");

	AST_DECAY_OPEN: assert property ( // see RULE4
		logic_ok && !decay_sel_driven |=> decay_mode_reg == DECAY_MIXED)
		else $error("Open decay pin not decoded as mixed");

endmodule : hbcdf_core

// ==== hbcdf_host.sv ====
`timescale 1ns/100ps

module hbcdf_host #(
	parameter int WAKE_CYC = 100_000
) (
	input  wire logic       clk_sys,
	output logic      [1:0] bridge_ctrl_in_a,
	output logic      [1:0] bridge_ctrl_in_b,
	output logic      [1:0] current_scale_msb,
	output logic      [1:0] current_scale_lsb,
	output logic            decay_sel_level,
	output logic            decay_sel_driven,
	output logic            active_low_logic_clear,
	output logic            active_low_power_down
);
	// Pins start low, as the pulldowns leave them before the host takes over.
	initial begin
		{bridge_ctrl_in_a, bridge_ctrl_in_b, current_scale_msb, current_scale_lsb} = 8'h00;
		{decay_sel_level, decay_sel_driven} = 2'h0;
		{active_low_logic_clear, active_low_power_down} = 2'h0;
	end

	task automatic pins(input logic [3:0] br, input logic [3:0] sc, input logic [1:0] dec);
		@(posedge clk_sys);
		{bridge_ctrl_in_a, bridge_ctrl_in_b} <= br;
		{current_scale_msb, current_scale_lsb} <= sc;
		{decay_sel_level, decay_sel_driven} <= dec;
	endtask : pins

	task automatic ctl(input logic clr, input logic run);
		@(posedge clk_sys);
		active_low_logic_clear <= clr;
		active_low_power_down  <= run;
		// The driver is not usable at once after leaving sleep, so the host holds off.
		if (run && !active_low_power_down) repeat (WAKE_CYC) @(posedge clk_sys);
	endtask : ctl
endmodule : hbcdf_host

// ==== hbcdf_core_tb.sv ====
`timescale 1ns/100ps

module hbcdf_core_tb;
	import hbcdf_pkg::*;
	logic              clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [1:0]        bridge_ctrl_in_a, bridge_ctrl_in_b, current_scale_msb, current_scale_lsb;
	logic [1:0]        chop_trip, winding_near_zero, overcurrent_trip;
	logic              decay_sel_level, decay_sel_driven, thermal_trip, supply_undervoltage_trip;
	logic              active_low_logic_clear, active_low_power_down;
	hbcdf_half_s [1:0] bridge_out_a, bridge_out_b;
	logic [3:0]        chop_scale_sel;
	logic              charge_pump_en, aux_regulator_en, fault_flag_out_o, fault_flag_out_oe;
	int                error_cnt, cmp_count;
	// Open-drain fault line with its pull-up.
	wire               fault_flag_out_i = ~fault_flag_out_oe;
	wire  [7:0]        pair = {bridge_out_a[0], bridge_out_b[0], bridge_out_a[1], bridge_out_b[1]};
	localparam logic [7:0] DRV = {HALF_HIGH, HALF_LOW, HALF_HIGH, HALF_LOW};
	localparam logic [7:0] REV = {HALF_LOW, HALF_HIGH, HALF_LOW, HALF_HIGH};
	localparam logic [7:0] LL  = {HALF_LOW, HALF_LOW, HALF_LOW, HALF_LOW};

	hbcdf_core hbcdf_core_inst (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .bridge_ctrl_in_a, .bridge_ctrl_in_b, .current_scale_msb,
		.current_scale_lsb, .decay_sel_level, .decay_sel_driven, .chop_trip, .winding_near_zero,
		.overcurrent_trip, .thermal_trip, .supply_undervoltage_trip, .active_low_logic_clear,
		.active_low_power_down, .bridge_out_a, .bridge_out_b, .chop_scale_sel, .charge_pump_en,
		.aux_regulator_en, .fault_flag_out_i, .fault_flag_out_o, .fault_flag_out_oe);

	hbcdf_host #(.WAKE_CYC(200)) hbcdf_host_inst (.clk_sys, .bridge_ctrl_in_a,
		.bridge_ctrl_in_b, .current_scale_msb, .current_scale_lsb, .decay_sel_level,
		.decay_sel_driven, .active_low_logic_clear, .active_low_power_down);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word

	task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= adr;
		pwdata <= dat;
		tick(1);
		penable <= 1'b1;
		tick(1);
		while (pready !== 1'b1) begin
			tick(1);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask : apb

	// Bridge 0 idles until a period boundary, which may be a whole period away.
	task automatic wait_drv();
		int n;
		n = 0;
		while (bridge_out_a[0] === HALF_OFF && bridge_out_b[0] === HALF_OFF && n < 2100) begin
			n++;
			tick(1);
		end
		check_word("drive start", 32'h1, 32'(n < 2100));
	endtask : wait_drv

	task automatic t_apb();
		apb(1'b0, ADDR_CFG, 32'h0);
		check_word("cfg reset", {16'h0000, OCP_QUAL_RST}, rd);
		apb(1'b1, ADDR_CFG, 32'hABCD0003);
		apb(1'b0, ADDR_CFG, 32'h0);
		check_word("cfg rw", 32'h00000003, rd);
		apb(1'b0, 8'h08, 32'h0);
		check_word("unmapped", 32'h00000001, {rd[30:0], err});
		check_word("apb ready", 32'h00000001, 32'(pready));
		$display("test apb done");
	endtask : t_apb

	// One full period per decay mode, sampled at fixed offsets from the drive start.
	task automatic t_chop(input int m);
		int ks[7] = '{374, 380, 700, 1450, 1550, 1999, 2000};
		logic [7:0] e;
		hbcdf_host_inst.ctl(1'b0, 1'b1);
		hbcdf_host_inst.pins(4'hC, 4'h0, m == 0 ? 2'b01 : m == 1 ? 2'b00 : 2'b11);
		hbcdf_host_inst.ctl(1'b1, 1'b1);
		chop_trip <= 2'b11;
		// The decay decode is held at mixed while clear is low, so let it settle first.
		tick(1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check_word("decay mode", 32'(1 << m), 32'(rd[10:8]));
		wait_drv();
		for (int k = 0; k <= 2000; k++) begin
			if (m == 2 && k == 600) winding_near_zero <= 2'b11;
			foreach (ks[i]) if (k == ks[i]) begin
				e = (i == 0 || i == 6) ? DRV : m == 0 ? LL : (m == 2 && i >= 2) ? 8'h00 :
					(m == 1 && i >= 4) ? LL : REV;
				check_word("chop bridge 0", 32'(e[7:4]), 32'(pair[7:4]));
				check_word("chop bridge 1", 32'(e[3:0]), 32'(pair[3:0]));
			end
			tick(1);
		end
		winding_near_zero <= 2'b00;
		chop_trip <= 2'b00;
		$display("test chop mode %0d done", m);
	endtask : t_chop

	task automatic t_map();
		logic [7:0] e;
		hbcdf_host_inst.pins(4'hC, 4'hA, 2'b01);
		wait_drv();
		for (int p = 0; p < 4; p++) begin
			hbcdf_host_inst.pins({1'b0, p[1], 1'b0, p[0]}, {1'b1, p == 2, 1'b1, p == 1}, 2'b01);
			tick(3);
			e = p == 0 ? 8'h00 : p == 1 ? 8'h60 : p == 2 ? 8'h90 : 8'h50;
			check_word("bridge map", 32'(e), 32'(pair));
			check_word("scale sel", {28'h0, 2'b11, p == 2, p == 1}, 32'(chop_scale_sel));
		end
		hbcdf_host_inst.ctl(1'b0, 1'b1);
		tick(2);
		check_word("clear off", 32'h0, 32'(pair));
		hbcdf_host_inst.ctl(1'b1, 1'b1);
		$display("test map done");
	endtask : t_map

	task automatic t_ocp();
		hbcdf_host_inst.pins(4'hC, 4'h0, 2'b01);
		apb(1'b1, ADDR_CFG, 32'h3);
		wait_drv();
		overcurrent_trip <= 2'b01;
		tick(3);
		overcurrent_trip <= 2'b00;
		tick(3);
		check_word("ocp short", 32'h0, 32'(fault_flag_out_oe));
		overcurrent_trip <= 2'b01;
		tick(4);
		overcurrent_trip <= 2'b00;
		tick(3);
		check_word("ocp latch", 32'h109, {fault_flag_out_oe, pair});
		apb(1'b0, ADDR_STATUS, 32'h0);
		check_word("ocp status", 32'h1, 32'(rd[1:0]));
		hbcdf_host_inst.ctl(1'b1, 1'b0);
		hbcdf_host_inst.ctl(1'b1, 1'b1);
		check_word("ocp held", 32'h1, 32'(fault_flag_out_oe));
		hbcdf_host_inst.ctl(1'b0, 1'b1);
		hbcdf_host_inst.ctl(1'b1, 1'b1);
		tick(2);
		check_word("ocp cleared", 32'h0, {fault_flag_out_o, fault_flag_out_oe});
		$display("test ocp done");
	endtask : t_ocp

	task automatic t_prot();
		wait_drv();
		thermal_trip <= 1'b1;
		tick(4);
		check_word("thermal", 32'h100, {fault_flag_out_oe, pair});
		thermal_trip <= 1'b0;
		tick(4);
		check_word("thermal end", 32'h0, 32'(fault_flag_out_oe));
		wait_drv();
		supply_undervoltage_trip <= 1'b1;
		tick(4);
		check_word("supply_undervoltage_trip", 32'h0, {charge_pump_en, aux_regulator_en, pair});
		supply_undervoltage_trip <= 1'b0;
		tick(4);
		check_word("supply_undervoltage_trip end", 32'h3, {charge_pump_en, aux_regulator_en});
		hbcdf_host_inst.ctl(1'b1, 1'b0);
		tick(4);
		check_word("sleep", 32'h0, {charge_pump_en, aux_regulator_en, pair});
		hbcdf_host_inst.ctl(1'b1, 1'b1);
		check_word("wake", 32'h3, {charge_pump_en, aux_regulator_en});
		$display("test protection done");
	endtask : t_prot

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (60000) @(posedge clk_sys);
		error_cnt++;
		$display("ERROR watchdog expected finish seen hang");
		summarize();
	end

	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{chop_trip, winding_near_zero, overcurrent_trip} = 6'h00;
		{thermal_trip, supply_undervoltage_trip} = 2'h0;
		error_cnt = 0;
		cmp_count = 0;
		tick(12);
		reset_n <= 1'b1;
		hbcdf_host_inst.ctl(1'b1, 1'b1);
		t_apb();
		for (int m = 0; m < 3; m++) t_chop(m);
		t_map();
		t_ocp();
		t_prot();
		summarize();
	end
endmodule : hbcdf_core_tb
